// ==== hw/dram_mode_pkg.sv ====
/*
 * Shared constants and types for the mode-register, calibration readout
 * and DLL-off latency block of a DDR3-class memory device.
 * Assumes a single 200 MHz core clock and synchronous active-high reset.
 */
package dram_mode_pkg;

    // Command pins as sampled from the controller
    typedef struct packed {
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [2:0]  ba;
        logic [12:0] addr;
    } cmd_pins_t;

    localparam int ADDR_W = 13;
    localparam int LAT_W = 5;
    localparam int LAT_DEPTH = 32;

    // Bank-address codes of the mode register set command
    localparam logic [2:0] BA_MR0 = 3'h0;
    localparam logic [2:0] BA_MR1 = 3'h1;
    localparam logic [2:0] BA_MR2 = 3'h2;
    localparam logic [2:0] BA_MR3 = 3'h3;

    // Field positions, MR1
    localparam int MR1_DLL_OFF_BIT = 0;
    localparam int MR1_AL_LSB = 3;
    localparam int MR1_WR_LEVEL_BIT = 7;

    // Field positions, MR2
    localparam int MR2_PASR_LSB = 0;
    localparam int MR2_CWL_LSB = 3;
    localparam int MR2_ASR_BIT = 6;
    localparam int MR2_SRT_BIT = 7;
    localparam int MR2_RTT_WR_LSB = 9;

    // Field positions, MR3
    localparam int MR3_SEL_LSB = 0;
    localparam int MR3_MPR_EN_BIT = 2;

    // Additive latency selector codes
    localparam logic [1:0] AL_OFF = 2'h0;
    localparam logic [1:0] AL_CL_MINUS1 = 2'h1;
    localparam logic [1:0] AL_CL_MINUS2 = 2'h2;

    // Write column latency code zero stands for this many cycles
    localparam logic [3:0] CWL_BASE = 4'h5;

    // Only latency pair guaranteed with the DLL switched off
    localparam logic [3:0] DLL_OFF_CL = 4'h6;
    localparam logic [3:0] DLL_OFF_CWL = 4'h6;

    // Write burst of eight beats lasts four clocks on the bus
    localparam logic [2:0] WR_BURST_CYCLES = 3'h4;

    // Reset values of the stored fields
    localparam logic [1:0] RST_AL_SEL = 2'h0;
    localparam logic [2:0] RST_CWL_SEL = 3'h0;
    localparam logic [1:0] RST_RTT_WR = 2'h0;
    localparam logic [2:0] RST_PASR = 3'h0;
    localparam logic [1:0] RST_MPR_SEL = 2'h0;

endpackage

// ==== hw/latency_pipe.sv ====
/*
 * Delay line that reproduces a one-cycle event a programmable number of
 * cycles later; overlapping events in flight are all kept.
 * Assumes delay is stable in the cycle fire is high.
 */
`timescale 1ns/1ps
module latency_pipe #(
    parameter int DEPTH = 32,
    parameter int DW = 5
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic fire,
    input wire logic [DW-1:0] delay,
    output logic out
);

    logic [DEPTH-1:0] sr_q;
    logic [DEPTH-1:0] sr_d;

    // A delay of zero is served as one cycle
    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_tap
            // Int compare so the top tap never aliases a zero delay
            localparam int TAP = i + 1;
            logic hit;
            assign hit = fire && ((int'(delay) == TAP) || (i == 0 && delay == '0));
            if (i == DEPTH - 1) begin : g_top
                assign sr_d[i] = hit;
            end else begin : g_mid
                assign sr_d[i] = sr_q[i+1] | hit;
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            sr_q <= '0;
        end else begin
            sr_q <= sr_d;
        end
    end

    assign out = sr_q[0];

endmodule

// ==== hw/dram_mode_reg_mpr_dll_off.sv ====
/*
 * Device-side mode register decode for MR1..MR3: write latency, self
 * refresh rate, dynamic write termination, calibration readout and
 * DLL-off read timing, with read and write event timing.
 * Assumes the controller pins arrive asynchronously and are sampled on
 * clk; the CAS latency comes from same-clock logic holding MR0.
 */
// Summary of operation
// - Write column latency comes from MR2 address bits A3 to A5.
// - Total write latency is additive latency plus write column latency, whole cycles.
// - With A6 set, thermal sensor picks refresh rate and A7 is ignored.
// - With A6 clear, A7 picks normal or extended range refresh rate.
// - MR2 A9 and A10 set dynamic write termination, switched during writes.
// - In write leveling only nominal termination applies, never dynamic one.
// - All four strobes low, BA1 BA0 high, BA2 low writes MR3.
// - Pattern select in MR3 is ignored while readout mode is off.
// - In readout mode every read returns the calibration pattern, not array.
// - Reset still works while calibration readout mode is enabled.
// - Chip select low with other strobes high is a no-operation.
// - Chip select high ignores all command inputs; ongoing work continues.
// - MR1 A0 set enters DLL-off mode until written back to zero.
// - DLL-off mode supports only CAS latency six with write column latency six.
// - DLL-off read strobe timing starts one cycle before AL plus CL.
// - All four strobes low, BA1 high, BA0 BA2 low writes MR2.
`timescale 1ns/1ps
module dram_mode_reg_mpr_dll_off #(
    parameter int LAT_DEPTH = dram_mode_pkg::LAT_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] ba,
    input wire logic [12:0] addr,
    input wire logic [3:0] cas_latency,
    input wire logic thermal_hot,
    output logic [3:0] cwl,
    output logic [4:0] write_latency,
    output logic [4:0] read_latency,
    output logic [1:0] additive_sel,
    output logic dll_off,
    output logic write_leveling,
    output logic asr_en,
    output logic refresh_ext_rate,
    output logic [2:0] pasr,
    output logic [1:0] rtt_wr,
    output logic dyn_odt_on,
    output logic mpr_en,
    output logic [1:0] mpr_sel,
    output logic latency_unsupported,
    output logic write_data_start,
    output logic array_read_start,
    output logic mpr_read_start
);

    // Block state apart from the latency timer shift registers, both synchroniser stages included
    typedef struct packed {
        dram_mode_pkg::cmd_pins_t pins_meta;
        dram_mode_pkg::cmd_pins_t pins_sync;
        logic cke_meta;
        logic cke_sync;
        logic hot_meta;
        logic hot_sync;
        logic dll_off;
        logic [1:0] al_sel;
        logic wr_level;
        logic [2:0] pasr;
        logic [2:0] cwl_sel;
        logic asr;
        logic srt;
        logic [1:0] rtt_wr;
        logic mpr_en;
        logic [1:0] mpr_sel;
        logic [3:0] cwl;
        logic [4:0] wl;
        logic [4:0] rl;
        logic [4:0] rd_delay;
        logic ext_rate;
        logic unsupported;
        logic [2:0] odt_cnt;
        logic dyn_odt;
    } state_t;

    state_t state_q;
    state_t state_d;

    dram_mode_pkg::cmd_pins_t pins_in;
    logic cmd_mrs;
    logic cmd_read;
    logic cmd_write;
    logic rd_fire_array;
    logic rd_fire_mpr;
    logic wr_fire;
    logic wr_start;
    logic arr_start;
    logic mpr_start;
    logic [4:0] al_cycles;
    logic [3:0] cl_q;

    assign pins_in.cs_n = cs_n;
    assign pins_in.ras_n = ras_n;
    assign pins_in.cas_n = cas_n;
    assign pins_in.we_n = we_n;
    assign pins_in.ba = ba;
    assign pins_in.addr = addr;

    ////////////////////////////////////////////////////////////////////////
    // Command decode on the synchronised pins
    // Taken only with clock enable high and chip select low

    always_comb begin
        cmd_mrs = 1'b0;
        cmd_read = 1'b0;
        cmd_write = 1'b0;
        if (state_q.cke_sync && !state_q.pins_sync.cs_n) begin
            unique case ({state_q.pins_sync.ras_n, state_q.pins_sync.cas_n,
                          state_q.pins_sync.we_n})
                3'h0: cmd_mrs = 1'b1;
                3'h5: cmd_read = 1'b1;
                3'h4: cmd_write = 1'b1;
                default: begin
                end
            endcase
        end
    end

    assign rd_fire_mpr = cmd_read && state_q.mpr_en;
    assign rd_fire_array = cmd_read && !state_q.mpr_en;
    // Writes are dropped in readout mode so the array cannot be disturbed
    assign wr_fire = cmd_write && !state_q.mpr_en;

    // A CAS latency change reaches the read delay two cycles later
    // CAS latency is taken from same-clock logic; no sync needed
    assign cl_q = cas_latency;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    // A command driven in cycle c decodes in c+2; fields follow in c+3,
    // cwl and rl in c+4, wl and rd_delay in c+5, so timed reads and writes should
    // wait three cycles after a mode write

    always_comb begin
        state_d = state_q;
        // Only the second stage of each synchroniser feeds logic
        state_d.pins_meta = pins_in;
        state_d.pins_sync = state_q.pins_meta;
        state_d.cke_meta = cke;
        state_d.cke_sync = state_q.cke_meta;
        state_d.hot_meta = thermal_hot;
        state_d.hot_sync = state_q.hot_meta;

        if (cmd_mrs) begin
            unique case (state_q.pins_sync.ba)
                dram_mode_pkg::BA_MR1: begin
                    state_d.dll_off =
                        state_q.pins_sync.addr[dram_mode_pkg::MR1_DLL_OFF_BIT];
                    state_d.al_sel =
                        state_q.pins_sync.addr[dram_mode_pkg::MR1_AL_LSB +: 2];
                    state_d.wr_level =
                        state_q.pins_sync.addr[dram_mode_pkg::MR1_WR_LEVEL_BIT];
                end
                dram_mode_pkg::BA_MR2: begin
                    state_d.pasr =
                        state_q.pins_sync.addr[dram_mode_pkg::MR2_PASR_LSB +: 3];
                    state_d.cwl_sel =
                        state_q.pins_sync.addr[dram_mode_pkg::MR2_CWL_LSB +: 3];
                    state_d.asr =
                        state_q.pins_sync.addr[dram_mode_pkg::MR2_ASR_BIT];
                    state_d.srt =
                        state_q.pins_sync.addr[dram_mode_pkg::MR2_SRT_BIT];
                    state_d.rtt_wr =
                        state_q.pins_sync.addr[dram_mode_pkg::MR2_RTT_WR_LSB +: 2];
                end
                dram_mode_pkg::BA_MR3: begin
                    state_d.mpr_en =
                        state_q.pins_sync.addr[dram_mode_pkg::MR3_MPR_EN_BIT];
                    if (state_q.pins_sync.addr[dram_mode_pkg::MR3_MPR_EN_BIT]) begin
                        state_d.mpr_sel =
                            state_q.pins_sync.addr[dram_mode_pkg::MR3_SEL_LSB +: 2];
                    end else begin
                        state_d.mpr_sel = 2'h0;
                    end
                end
                // MR0 and unused bank codes leave every field alone
                default: begin
                end
            endcase
        end

        state_d.cwl = dram_mode_pkg::CWL_BASE + {1'b0, state_q.cwl_sel};
        state_d.wl = al_cycles + {1'b0, state_q.cwl};
        state_d.rl = al_cycles + {1'b0, cl_q};
        // A zero latency is left as is rather than wrapping
        // one cycle early without DLL
        if (state_q.dll_off && state_q.rl != 5'h0) begin
            state_d.rd_delay = state_q.rl - 5'h1;
        end else begin
            state_d.rd_delay = state_q.rl;
        end

        if (state_q.asr) begin
            state_d.ext_rate = state_q.hot_sync;
        end else begin
            state_d.ext_rate = state_q.srt;
        end

        // only CL6 and CWL6 without DLL
        state_d.unsupported = state_q.dll_off &&
            (cl_q != dram_mode_pkg::DLL_OFF_CL || state_q.cwl != dram_mode_pkg::DLL_OFF_CWL);

        // Burst of eight assumed; a chopped burst closes the window late
        // termination switched per write burst
        if (wr_start) begin
            state_d.odt_cnt = dram_mode_pkg::WR_BURST_CYCLES;
        end else if (state_q.odt_cnt != 3'h0) begin
            state_d.odt_cnt = state_q.odt_cnt - 3'h1;
        end
        state_d.dyn_odt = (state_d.odt_cnt != 3'h0) && (state_q.rtt_wr != 2'h0)
                          && !state_q.wr_level;
    end

    always_comb begin
        unique case (state_q.al_sel)
            dram_mode_pkg::AL_CL_MINUS1: al_cycles = {1'b0, cl_q} - 5'h1;
            dram_mode_pkg::AL_CL_MINUS2: al_cycles = {1'b0, cl_q} - 5'h2;
            // Reserved code is treated as no additive latency
            default: al_cycles = 5'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk) begin
        // Synchronised chip select resets high, reading as deselect
        // reset honoured in readout mode
        if (rst) begin
            state_q <= '0;
            state_q.pins_meta.cs_n <= 1'b1;
            state_q.pins_sync.cs_n <= 1'b1;
            state_q.al_sel <= dram_mode_pkg::RST_AL_SEL;
            state_q.cwl_sel <= dram_mode_pkg::RST_CWL_SEL;
            state_q.rtt_wr <= dram_mode_pkg::RST_RTT_WR;
            state_q.pasr <= dram_mode_pkg::RST_PASR;
            state_q.mpr_sel <= dram_mode_pkg::RST_MPR_SEL;
            state_q.cwl <= dram_mode_pkg::CWL_BASE;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Latency timers; reads and writes may overlap in flight
    // Depth must be at least the largest AL plus CL or CWL; a longer delay
    // would be lost without any warning

    latency_pipe #(
        .DEPTH(LAT_DEPTH),
        .DW(dram_mode_pkg::LAT_W)
    ) u_wr_pipe (
        .clk(clk),
        .rst(rst),
        .fire(wr_fire),
        .delay(state_q.wl),
        .out(wr_start)
    );

    latency_pipe #(
        .DEPTH(LAT_DEPTH),
        .DW(dram_mode_pkg::LAT_W)
    ) u_rd_pipe (
        .clk(clk),
        .rst(rst),
        .fire(rd_fire_array),
        .delay(state_q.rd_delay),
        .out(arr_start)
    );

    latency_pipe #(
        .DEPTH(LAT_DEPTH),
        .DW(dram_mode_pkg::LAT_W)
    ) u_mpr_pipe (
        .clk(clk),
        .rst(rst),
        .fire(rd_fire_mpr),
        .delay(state_q.rd_delay),
        .out(mpr_start)
    );

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Mode fields and latencies
    assign cwl = state_q.cwl;
    assign write_latency = state_q.wl;
    assign read_latency = state_q.rl;
    assign additive_sel = state_q.al_sel;
    assign dll_off = state_q.dll_off;
    assign write_leveling = state_q.wr_level;
    assign asr_en = state_q.asr;
    assign refresh_ext_rate = state_q.ext_rate;
    assign pasr = state_q.pasr;
    // Termination, readout and unsupported latency flag
    assign rtt_wr = state_q.rtt_wr;
    assign dyn_odt_on = state_q.dyn_odt;
    assign mpr_en = state_q.mpr_en;
    assign mpr_sel = state_q.mpr_sel;
    assign latency_unsupported = state_q.unsupported;

    // Event pulses, one cycle each, straight from the timer taps
    assign write_data_start = wr_start;
    assign array_read_start = arr_start;
    assign mpr_read_start = mpr_start;

endmodule

// ==== tb/dram_mode_chk.sv ====
/*
 * Port assertions for the mode register block.
 * Bound to every instance of it; sees only its ports.
 */
`timescale 1ns/1ps
module dram_mode_chk #(
    parameter int LAT_DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] ba,
    input wire logic [12:0] addr,
    input wire logic [3:0] cas_latency,
    input wire logic thermal_hot,
    input wire logic [3:0] cwl,
    input wire logic [4:0] write_latency,
    input wire logic [4:0] read_latency,
    input wire logic [1:0] additive_sel,
    input wire logic dll_off,
    input wire logic write_leveling,
    input wire logic asr_en,
    input wire logic refresh_ext_rate,
    input wire logic [2:0] pasr,
    input wire logic [1:0] rtt_wr,
    input wire logic dyn_odt_on,
    input wire logic mpr_en,
    input wire logic [1:0] mpr_sel,
    input wire logic latency_unsupported,
    input wire logic write_data_start
);
    logic mrs;
    logic [4:0] al;
    logic [12:0] a_q;

    assign mrs = cke && !cs_n && !ras_n && !cas_n && !we_n;
    always_comb begin
        case (additive_sel)
            2'h1: al = {1'b0, cas_latency} - 5'h01;
            2'h2: al = {1'b0, cas_latency} - 5'h02;
            default: al = 5'h00;
        endcase
    end
    // Mode word last seen on the pins
    always_ff @(posedge clk) begin
        if (mrs) begin
            a_q <= addr;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////
    AST_MR2_FIELDS: assert property (
        mrs && ba == 3'h2 ##1 cs_n [*6] |-> cwl == 4'h5 + {1'b0, a_q[5:3]} && asr_en == a_q[6]
        && rtt_wr == a_q[10:9] && pasr == a_q[2:0] && (a_q[6] || refresh_ext_rate == a_q[7]))
        else $error("MR2 fields wrong");
    AST_MR3_FIELDS: assert property (
        mrs && ba == 3'h3 ##1 cs_n [*6] |-> mpr_en == a_q[2] && mpr_sel == (a_q[2] ? a_q[1:0] : 2'h0))
        else $error("MR3 fields wrong");
    AST_WL_SUM: assert property (
        ($stable(cwl) && $stable(al)) [*5] |-> write_latency == al + {1'b0, cwl})
        else $error("write latency not AL plus CWL");
    AST_RL_SUM: assert property (
        ($stable(al) && $stable(cas_latency)) [*5] |-> read_latency == al + {1'b0, cas_latency})
        else $error("read latency not AL plus CL");
    AST_ASR_RATE: assert property (
        (asr_en && $stable(thermal_hot)) [*5] |-> refresh_ext_rate == thermal_hot)
        else $error("refresh rate ignores sensor");
    AST_DLL_OFF_PAIR: assert property (
        ($stable(dll_off) && $stable(cas_latency) && $stable(cwl)) [*3] |-> latency_unsupported
        == (dll_off && (cas_latency != dram_mode_pkg::DLL_OFF_CL || cwl != dram_mode_pkg::DLL_OFF_CWL)))
        else $error("unsupported latency flag wrong");
    AST_DESELECT: assert property (
        cs_n [*5] |-> $stable(asr_en) && $stable(rtt_wr) && $stable(mpr_en) && $stable(dll_off))
        else $error("field changed while deselected");
    AST_NOP: assert property (
        (!cs_n && ras_n && cas_n && we_n) [*5] |-> $stable(asr_en) && $stable(mpr_en))
        else $error("field changed by no-operation");
    AST_RESET: assert property (
        $fell(rst) |-> !mpr_en && !dll_off && !asr_en && rtt_wr == 2'h0 && cwl == 4'h5)
        else $error("fields not cleared by reset");
    AST_DYN_TERM: assert property (
        write_data_start && rtt_wr != 2'h0 && !write_leveling |=> dyn_odt_on [*4])
        else $error("write termination window wrong");
endmodule

bind dram_mode_reg_mpr_dll_off dram_mode_chk #(.LAT_DEPTH(LAT_DEPTH)) u_chk (
    .clk, .rst, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .cas_latency, .thermal_hot,
    .cwl, .write_latency, .read_latency, .additive_sel, .dll_off, .write_leveling, .asr_en,
    .refresh_ext_rate, .pasr, .rtt_wr, .dyn_odt_on, .mpr_en, .mpr_sel, .latency_unsupported,
    .write_data_start
);

// ==== tb/ctrl_model.sv ====
/*
 * Memory controller model: one command on the pins per cycle of go.
 * Assumes the bench changes go and cmd on the rising edge.
 */
`timescale 1ns/1ps
module ctrl_model (
    input wire logic clk,
    input wire logic go,
    input wire logic cke_req,
    input wire dram_mode_pkg::cmd_pins_t cmd,
    output dram_mode_pkg::cmd_pins_t pins,
    output logic cke
);
    dram_mode_pkg::cmd_pins_t word;

    always_comb begin
        word = cmd;
        if (!cmd.ras_n && !cmd.cas_n && !cmd.we_n && cmd.ba[1]) begin
            word.ba[2] = 1'b0;
            word.addr = cmd.addr & (cmd.ba[0] ? 13'h0007 : 13'h06FF);
        end
    end
    initial begin
        pins = '1;
        cke = 1'b0;
    end
    // Idle lines toggle so a stale word never looks valid
    always @(posedge clk) begin
        cke <= cke_req;
        if (go) begin
            pins <= word;
        end else begin
            pins <= {1'b1, ~pins[18:0]};
        end
    end
endmodule

// ==== tb/dram_mode_reg_mpr_dll_off_tb.sv ====
/*
 * Self-checking bench for the mode register block.
 * Commands go through the controller model; clock 200 MHz.
 */
`timescale 1ns/1ps
module dram_mode_reg_mpr_dll_off_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic go = 1'b0;
    logic cke_req = 1'b1;
    logic cke, thermal_hot = 1'b0;
    logic [3:0] cas_latency = 4'h6;
    dram_mode_pkg::cmd_pins_t cmd = '1;
    dram_mode_pkg::cmd_pins_t pins;
    logic [3:0] cwl;
    logic [4:0] write_latency, read_latency;
    logic [1:0] additive_sel, rtt_wr, mpr_sel;
    logic [2:0] pasr;
    logic dll_off, write_leveling, asr_en, refresh_ext_rate, dyn_odt_on, mpr_en;
    logic latency_unsupported, write_data_start, array_read_start, mpr_read_start;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;
    int k;

    always #2.5 clk = ~clk;
    ctrl_model u_ctrl (.clk, .go, .cke_req, .cmd, .pins, .cke);
    dram_mode_reg_mpr_dll_off #(.LAT_DEPTH(32)) DUT (
        .clk, .rst, .cke, .cs_n(pins.cs_n), .ras_n(pins.ras_n), .cas_n(pins.cas_n),
        .we_n(pins.we_n), .ba(pins.ba), .addr(pins.addr), .cas_latency, .thermal_hot,
        .cwl, .write_latency, .read_latency, .additive_sel, .dll_off, .write_leveling,
        .asr_en, .refresh_ext_rate, .pasr, .rtt_wr, .dyn_odt_on, .mpr_en, .mpr_sel,
        .latency_unsupported, .write_data_start, .array_read_start, .mpr_read_start
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic check(input string what, input logic [12:0] seen, input logic [12:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // Op is {cs_n, ras_n, cas_n, we_n}
    task automatic send(input logic [3:0] op, input logic [2:0] b, input logic [12:0] a, int n);
        @(posedge clk);
        cmd <= {op, b, a};
        go <= 1'b1;
        repeat (n) @(posedge clk);
        go <= 1'b0;
    endtask
    task automatic issue(input logic [3:0] op, input logic [2:0] b, input logic [12:0] a);
        send(op, b, a, 1);
        repeat (8) @(posedge clk);
        #1;
    endtask
    // delay counted in own clock from the pin sample
    task automatic lat(input logic [3:0] op, input int sel);
        send(op, 3'h0, 13'h0000, 1);
        k = 0;
        for (int i = 1; i < 40 && k == 0; i++) begin
            @(posedge clk);
            #1;
            k = ({mpr_read_start, array_read_start, write_data_start} === 3'h1 << sel) ? i : 0;
        end
    endtask
    task automatic wait_cycle();
        @(posedge clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_cwl();
        check("cwl", cwl, 13'h5);
        for (int c = 0; c < 8; c++) begin
            issue(4'h0, 3'h2, 13'(c) << 3);
            check("cwl", cwl, 13'(5 + c));
            check("wl", write_latency, 13'(5 + c));
        end
        for (int s = 1; s < 3; s++) begin
            issue(4'h0, 3'h1, 13'(s) << 3);
            check("wl", write_latency, 13'(18 - s));
            check("rl", read_latency, 13'(12 - s));
            check("al_sel", additive_sel, 13'(s));
            lat(4'h4, 0);
            check("wr_delay", k, 13'(20 - s));
        end
        issue(4'h0, 3'h1, 13'h0000);
    endtask
    task automatic t_refresh();
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            thermal_hot <= i[0];
            // auto refresh or extended bit set before hot use
            issue(4'h0, 3'h2, {2'h0, i[1:0], 1'b0, i[1], i[2], 3'h0, i[2:0]});
            check("asr", asr_en, 13'(i[2]));
            check("rate", refresh_ext_rate, 13'(i[2] ? i[0] : i[1]));
            check("rtt", rtt_wr, 13'(i[1:0]));
            check("pasr", pasr, 13'(i[2:0]));
        end
    endtask
    task automatic t_odt();
        issue(4'h0, 3'h2, 13'h0200);
        lat(4'h4, 0);
        check("wr_delay", k, 13'h7);
        repeat (4) begin
            wait_cycle();
            check("dyn", dyn_odt_on, 13'h1);
        end
        wait_cycle();
        check("dyn", dyn_odt_on, 13'h0);
        issue(4'h0, 3'h1, 13'h0080);
        check("wr_level", write_leveling, 13'h1);
        lat(4'h4, 0);
        repeat (6) begin
            wait_cycle();
            check("dyn", dyn_odt_on, 13'h0);
        end
        issue(4'h0, 3'h1, 13'h0000);
    endtask
    task automatic t_ignore();
        issue(4'h8, 3'h2, 13'h0040);
        check("asr", asr_en, 13'h0);
        send(4'h7, 3'h2, 13'h0040, 6);
        issue(4'h7, 3'h2, 13'h0040);
        check("asr", asr_en, 13'h0);
        @(posedge clk);
        cke_req <= 1'b0;
        issue(4'h0, 3'h2, 13'h0040);
        check("asr", asr_en, 13'h0);
        @(posedge clk);
        cke_req <= 1'b1;
    endtask
    task automatic t_mpr();
        issue(4'h0, 3'h3, 13'h0003);
        check("mpr_en", mpr_en, 13'h0);
        check("mpr_sel", mpr_sel, 13'h0);
        check("cwl", cwl, 13'h5);
        issue(4'h0, 3'h3, 13'h0006);
        check("mpr_sel", mpr_sel, 13'h2);
        lat(4'h5, 2);
        check("mpr_delay", k, 13'h8);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) wait_cycle();
        check("mpr_en", mpr_en, 13'h0);
    endtask
    task automatic t_dll();
        issue(4'h0, 3'h2, 13'h0008);
        issue(4'h0, 3'h1, 13'h0001);
        check("dll_off", dll_off, 13'h1);
        check("unsup", latency_unsupported, 13'h0);
        lat(4'h5, 1);
        check("rd_delay", k, 13'h7);
        @(posedge clk);
        cas_latency <= 4'h7;
        repeat (4) wait_cycle();
        check("unsup", latency_unsupported, 13'h1);
        @(posedge clk);
        cas_latency <= 4'h6;
        issue(4'h0, 3'h1, 13'h0000);
        check("dll_off", dll_off, 13'h0);
        lat(4'h5, 1);
        check("rd_delay", k, 13'h8);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (4) wait_cycle();
        t_cwl();
        t_refresh();
        t_odt();
        t_ignore();
        t_mpr();
        t_dll();
        stop_test();
    end
endmodule
